//--- inc/bus_cycle_cfg.svh
// Constants for the bus cycle sequencer: register map, field positions, codes
`ifndef BUS_CYCLE_CFG_SVH
`define BUS_CYCLE_CFG_SVH

// APB register byte addresses
`define REG_FCW 8'h00
`define REG_PC 8'h04
`define REG_NSAP 8'h08
`define REG_CYCLE_CMD 8'h0c
`define REG_CYCLE_DATA 8'h10
`define REG_STATUS 8'h14
`define REG_TRAP_REQ 8'h18
`define REG_SAVED_PC 8'h1c
`define REG_SAVED_FCW 8'h20
`define REG_SAVED_ID 8'h24
`define REG_AREA_BASE 8'h28
`define REG_AREA_LAST 8'h34

// Flag and control word fields and reset value
`define FCW_MODE_BIT 14
`define FCW_VIE_BIT 12
`define FCW_NONVECTORED_IRQ_ENABLE_BIT 11
`define FCW_RESET 16'h0000

// Cycle command register fields
`define CMD_PORT_LSB 0
`define CMD_PORT_MSB 15
`define CMD_KIND_LSB 16
`define CMD_KIND_MSB 17
`define CMD_INPUT_BIT 18
`define CMD_BYTE_BIT 19

// Trap request register bits
`define TRAP_SYSCALL_BIT 0
`define TRAP_UNIMPL_BIT 1

// Status line codes
`define STATUS_INTERNAL 4'h0
`define STATUS_REFRESH 4'h1
`define STATUS_NORMAL_IO 4'h2
`define STATUS_SPECIAL_IO 4'h3

// Cause identifiers pushed with the saved status
`define ID_SYSCALL 16'h0001
`define ID_UNIMPL 16'h0002
`define ID_PRIV 16'h0003
`define ID_NMI 16'h0010
`define ID_VECTORED 16'h0020
`define ID_NONVECTORED 16'h0030

// Refresh address step keeps bit 0 low
`define REFRESH_STEP 9'h002
`define SYNC_RESET 21'h1f0000

`endif

//--- inc/bus_cycle_pkg.sv
// Types shared by the bus cycle sequencer
package bus_cycle_pkg;

    typedef enum logic [1:0] {
        KIND_INTERNAL = 2'h0,
        KIND_REFRESH = 2'h1,
        KIND_NORMAL_IO = 2'h2,
        KIND_SPECIAL_IO = 2'h3
    } cycle_kind_type;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_T1 = 6'h02,
        ST_T2 = 6'h04,
        ST_TWA = 6'h08,
        ST_TW = 6'h10,
        ST_T3 = 6'h20
    } seq_state_type;

    typedef struct packed {
        logic is_byte;
        logic is_input;
        cycle_kind_type kind;
        logic [15:0] port;
    } cycle_cmd_type;

    typedef struct packed {
        logic valid;
        logic [2:0] cause;
        logic [1:0] slot;
        logic [15:0] id;
    } event_pick_type;

endpackage

//--- src/bus_cycle_sequencer.sv
// Bus cycle sequencer with status word, event arbitration and APB register access
`timescale 1ns/1ps
`include "bus_cycle_cfg.svh"

module bus_cycle_sequencer
    import bus_cycle_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] muxed_addr_data_bus_in,
    output logic [15:0] muxed_addr_data_bus_out,
    output logic muxed_addr_data_bus_oe,
    output logic address_strobe_n,
    output logic data_strobe_n,
    output logic memory_request_n,
    output logic read_write,
    output logic byte_word,
    output logic normal_system,
    output logic [3:0] cycle_status_code,
    output logic control_oe,
    input wire logic wait_n,
    input wire logic bus_request_n,
    output logic bus_acknowledge_n,
    input wire logic nmi_n,
    input wire logic vectored_irq_n,
    input wire logic nonvectored_irq_n
);

    // Pick the highest event; traps outrank every interrupt class
    function automatic event_pick_type pick_event(input logic [2:0] traps, input logic nmi,
                                                  input logic vi, input logic nvi);
        event_pick_type p;
        p = '0;
        p.valid = 1'b1;
        if (traps[0]) begin
            p.cause = 3'h1;
            p.slot = 2'h0;
            p.id = `ID_SYSCALL;
        end else if (traps[1]) begin
            p.cause = 3'h2;
            p.slot = 2'h0;
            p.id = `ID_UNIMPL;
        end else if (traps[2]) begin
            p.cause = 3'h3;
            p.slot = 2'h0;
            p.id = `ID_PRIV;
        end else if (nmi) begin
            p.cause = 3'h4;
            p.slot = 2'h1;
            p.id = `ID_NMI;
        end else if (vi) begin
            p.cause = 3'h5;
            p.slot = 2'h2;
            p.id = `ID_VECTORED;
        end else if (nvi) begin
            p.cause = 3'h6;
            p.slot = 2'h3;
            p.id = `ID_NONVECTORED;
        end else begin
            p.valid = 1'b0;
        end
        return p;
    endfunction

    seq_state_type state_reg;
    seq_state_type state_next;
    cycle_cmd_type cmd_reg;
    logic cmd_pending_reg;
    logic [15:0] fcw_reg;
    logic [15:0] pc_reg;
    logic [15:0] nsap_reg;
    logic [15:0] out_data_reg;
    logic [15:0] in_data_reg;
    logic [15:0] saved_pc_reg;
    logic [15:0] saved_fcw_reg;
    logic [15:0] saved_id_reg;
    logic [15:0] area_pc_reg [4];
    logic [15:0] area_fcw_reg [4];
    logic [2:0] trap_reg;
    logic nmi_latch_reg;
    logic nmi_prev_reg;
    logic [8:0] refresh_addr_reg;
    logic [20:0] sync1_reg;
    logic [20:0] sync2_reg;
    logic wait_s;
    logic busrq_s;
    logic nmi_s;
    logic vi_s;
    logic nvi_s;
    logic [15:0] bus_s;
    logic apb_wr;
    logic apb_rd;
    logic addr_ok;
    logic cmd_write;
    logic cmd_is_io;
    logic priv_violation;
    logic is_io;
    logic event_take;
    logic [1:0] area_idx;
    event_pick_type pick;
    logic [2:0] trap_set;
    logic [2:0] trap_clr;

    // Pins from outside the clock domain pass two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= `SYNC_RESET;
            sync2_reg <= `SYNC_RESET;
        end else begin
            sync1_reg <= {wait_n, bus_request_n, nmi_n, vectored_irq_n, nonvectored_irq_n,
                          muxed_addr_data_bus_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign {wait_s, busrq_s, nmi_s, vi_s, nvi_s, bus_s} = sync2_reg;

    // APB decode; every access completes with no wait states
    assign pready = 1'b1;
    assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `REG_AREA_LAST);
    assign apb_wr = psel && penable && pwrite && addr_ok;
    assign apb_rd = psel && !penable && !pwrite;
    assign pslverr = psel && penable && !addr_ok;
    assign cmd_write = apb_wr && (paddr == `REG_CYCLE_CMD) && !cmd_pending_reg;
    assign cmd_is_io = pwdata[`CMD_KIND_MSB];
    assign priv_violation = cmd_write && cmd_is_io && !fcw_reg[`FCW_MODE_BIT];
    assign is_io = cmd_reg.kind[1];

    // Event selection is only made between machine cycles
    assign pick = pick_event(trap_reg, nmi_latch_reg,
                             !vi_s && fcw_reg[`FCW_VIE_BIT],
                             !nvi_s && fcw_reg[`FCW_NONVECTORED_IRQ_ENABLE_BIT]);
    assign event_take = pick.valid && (state_reg == ST_IDLE);
    assign area_idx = 2'(nsap_reg[1:0] + pick.slot);

    // Read data is captured in the setup phase so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (apb_rd) begin
            prdata <= 32'h0;
            unique case (paddr)
                `REG_FCW: prdata <= {16'h0, fcw_reg};
                `REG_PC: prdata <= {16'h0, pc_reg};
                `REG_NSAP: prdata <= {16'h0, nsap_reg};
                `REG_CYCLE_CMD: prdata <= {12'h0, cmd_reg};
                `REG_CYCLE_DATA: prdata <= {in_data_reg, out_data_reg};
                `REG_STATUS: prdata <= {16'h0, refresh_addr_reg, nmi_latch_reg, trap_reg,
                                        bus_acknowledge_n, cmd_pending_reg,
                                        state_reg != ST_IDLE};
                `REG_TRAP_REQ: prdata <= {29'h0, trap_reg};
                `REG_SAVED_PC: prdata <= {16'h0, saved_pc_reg};
                `REG_SAVED_FCW: prdata <= {16'h0, saved_fcw_reg};
                `REG_SAVED_ID: prdata <= {16'h0, saved_id_reg};
                default: begin
                    if (addr_ok && paddr >= `REG_AREA_BASE) begin
                        prdata <= {area_fcw_reg[2'(paddr[3:2] - 2'h2)],
                                   area_pc_reg[2'(paddr[3:2] - 2'h2)]};
                    end
                end
            endcase
        end
    end

    // Status word and program counter: an event load beats a software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fcw_reg <= `FCW_RESET;
            pc_reg <= 16'h0;
            saved_pc_reg <= 16'h0;
            saved_fcw_reg <= 16'h0;
            saved_id_reg <= 16'h0;
        end else if (event_take) begin
            saved_pc_reg <= pc_reg;
            saved_fcw_reg <= fcw_reg;
            saved_id_reg <= pick.id;
            fcw_reg <= area_fcw_reg[area_idx];
            pc_reg <= area_pc_reg[area_idx];
        end else if (apb_wr && paddr == `REG_FCW) begin
            fcw_reg <= pwdata[15:0];
        end else if (apb_wr && paddr == `REG_PC) begin
            pc_reg <= pwdata[15:0];
        end
    end

    // Pointer, output data and the new status area entries
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nsap_reg <= 16'h0;
            out_data_reg <= 16'h0;
            for (int i = 0; i < 4; i++) begin
                area_pc_reg[i] <= 16'h0;
                area_fcw_reg[i] <= 16'h0;
            end
        end else if (apb_wr) begin
            if (paddr == `REG_NSAP) begin
                nsap_reg <= pwdata[15:0];
            end
            if (paddr == `REG_CYCLE_DATA) begin
                out_data_reg <= pwdata[15:0];
            end
            if (paddr >= `REG_AREA_BASE) begin
                area_pc_reg[2'(paddr[3:2] - 2'h2)] <= pwdata[15:0];
                area_fcw_reg[2'(paddr[3:2] - 2'h2)] <= pwdata[31:16];
            end
        end
    end

    // Trap and non-maskable flags; a new request in the clearing cycle survives
    assign trap_set = {priv_violation,
                       apb_wr && paddr == `REG_TRAP_REQ && pwdata[`TRAP_UNIMPL_BIT],
                       apb_wr && paddr == `REG_TRAP_REQ && pwdata[`TRAP_SYSCALL_BIT]};
    assign trap_clr = {event_take && pick.cause == 3'h3, event_take && pick.cause == 3'h2,
                       event_take && pick.cause == 3'h1};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_reg <= 3'h0;
            nmi_latch_reg <= 1'b0;
            nmi_prev_reg <= 1'b1;
        end else begin
            trap_reg <= trap_set | (trap_reg & ~trap_clr);
            nmi_prev_reg <= nmi_s;
            // Falling edge is stored; the level alone would retrigger
            nmi_latch_reg <= (nmi_prev_reg && !nmi_s) ||
                             (nmi_latch_reg && !(event_take && pick.cause == 3'h4));
        end
    end

    // Command register; an I/O request outside system mode never starts
    // Pending holds until T3 so a new command cannot change a running cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= '0;
            cmd_pending_reg <= 1'b0;
        end else if (cmd_write && !priv_violation) begin
            cmd_reg <= pwdata[19:0];
            cmd_pending_reg <= 1'b1;
        end else if (state_reg == ST_T3) begin
            cmd_pending_reg <= 1'b0;
        end
    end

    // Grant the bus only between machine cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_acknowledge_n <= 1'b1;
        end else if (state_reg == ST_IDLE && state_next == ST_IDLE) begin
            bus_acknowledge_n <= busrq_s;
        end
    end

    // Sequencer: three clocks for internal and refresh, four or more for I/O
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (cmd_pending_reg && bus_acknowledge_n && busrq_s && !event_take) begin
                    state_next = ST_T1;
                end
            end
            ST_T1: state_next = ST_T2;
            ST_T2: state_next = is_io ? ST_TWA : ST_T3;
            ST_TWA, ST_TW: state_next = wait_s ? ST_T3 : ST_TW;
            ST_T3: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Refresh row counter steps by two so bit 0 stays low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refresh_addr_reg <= 9'h0;
        end else if (state_reg == ST_T3 && cmd_reg.kind == KIND_REFRESH) begin
            refresh_addr_reg <= 9'(refresh_addr_reg + `REFRESH_STEP);
        end
    end

    // Input data taken at T3; the synchroniser delay means it shows the bus while
    // the data strobe was still low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_data_reg <= 16'h0;
        end else if (state_reg == ST_T3 && is_io && cmd_reg.is_input) begin
            if (!cmd_reg.is_byte) begin
                in_data_reg <= bus_s;
            end else if (cmd_reg.port[0]) begin
                in_data_reg <= {8'h00, bus_s[7:0]};
            end else begin
                in_data_reg <= {8'h00, bus_s[15:8]};
            end
        end
    end

    // Strobes and status lines are registered from the next state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_strobe_n <= 1'b1;
            data_strobe_n <= 1'b1;
            memory_request_n <= 1'b1;
            cycle_status_code <= `STATUS_INTERNAL;
        end else begin
            address_strobe_n <= !(state_next == ST_T1);
            data_strobe_n <= !(is_io && (state_next == ST_T2 || state_next == ST_TWA ||
                               state_next == ST_TW));
            memory_request_n <= !(cmd_reg.kind == KIND_REFRESH &&
                                  state_next != ST_IDLE);
            if (state_next == ST_T1) begin
                unique case (cmd_reg.kind)
                    KIND_INTERNAL: cycle_status_code <= `STATUS_INTERNAL;
                    KIND_REFRESH: cycle_status_code <= `STATUS_REFRESH;
                    KIND_NORMAL_IO: cycle_status_code <= `STATUS_NORMAL_IO;
                    KIND_SPECIAL_IO: cycle_status_code <= `STATUS_SPECIAL_IO;
                endcase
            end
        end
    end

    // Direction, width and mode: refresh holds them, internal holds mode and width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_write <= 1'b1;
            byte_word <= 1'b0;
            normal_system <= 1'b1;
        end else if (state_next == ST_T1) begin
            unique case (cmd_reg.kind)
                KIND_INTERNAL: read_write <= 1'b1;
                KIND_REFRESH: read_write <= read_write;
                KIND_NORMAL_IO, KIND_SPECIAL_IO: begin
                    read_write <= cmd_reg.is_input;
                    byte_word <= cmd_reg.is_byte;
                    normal_system <= 1'b0;
                end
            endcase
        end else if (state_next == ST_IDLE) begin
            normal_system <= !fcw_reg[`FCW_MODE_BIT];
        end
    end

    // Address/data bus: address in T1, then only I/O output drives it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            muxed_addr_data_bus_out <= 16'h0;
            muxed_addr_data_bus_oe <= 1'b0;
        end else begin
            muxed_addr_data_bus_oe <= 1'b0;
            if (state_next == ST_T1) begin
                muxed_addr_data_bus_oe <= 1'b1;
                unique case (cmd_reg.kind)
                    KIND_INTERNAL: muxed_addr_data_bus_out <= 16'h0;
                    KIND_REFRESH: muxed_addr_data_bus_out <= {7'h00, refresh_addr_reg};
                    KIND_NORMAL_IO, KIND_SPECIAL_IO: begin
                        muxed_addr_data_bus_out <= cmd_reg.port;
                    end
                endcase
            end else if (is_io && !cmd_reg.is_input && state_next != ST_IDLE) begin
                muxed_addr_data_bus_oe <= 1'b1;
                if (cmd_reg.is_byte) begin
                    muxed_addr_data_bus_out <= {2{out_data_reg[7:0]}};
                end else begin
                    muxed_addr_data_bus_out <= out_data_reg;
                end
            end
        end
    end

    // Control group floats while another master owns the bus
    assign control_oe = bus_acknowledge_n;

endmodule

//--- test/bus_cycle_sequencer_sva.sv
// Pin-side assertions for the bus cycle sequencer
`timescale 1ns/1ps
module bus_cycle_sequencer_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic address_strobe_n,
    input wire logic data_strobe_n,
    input wire logic memory_request_n,
    input wire logic read_write,
    input wire logic normal_system,
    input wire logic [3:0] cycle_status_code,
    input wire logic [15:0] muxed_addr_data_bus_out,
    input wire logic muxed_addr_data_bus_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic t1;
    logic io;
    // Cycle start and I/O kind decode shared by the checks
    assign t1 = !address_strobe_n;
    assign io = cycle_status_code[3:1] == 3'h1;
    a_strobe_one_clock: assert property (t1 |=> address_strobe_n)
        else $error("strobe too long");
    a_cycle_min_len: assert property ($fell(address_strobe_n) |=> address_strobe_n [*3])
        else $error("cycle too short");
    a_internal_levels: assert property (t1 && cycle_status_code == 4'h0 |->
        (data_strobe_n && memory_request_n && read_write) [*3])
        else $error("internal levels");
    a_internal_float: assert property (t1 && cycle_status_code == 4'h0 |=>
        !muxed_addr_data_bus_oe [*2]) else $error("internal bus driven");
    a_refresh_addr: assert property (t1 && cycle_status_code == 4'h1 |->
        muxed_addr_data_bus_oe && !muxed_addr_data_bus_out[0]) else $error("refresh addr");
    a_refresh_levels: assert property (t1 && cycle_status_code == 4'h1 |->
        (!memory_request_n && data_strobe_n) [*3] ##0 !muxed_addr_data_bus_oe)
        else $error("refresh levels");
    a_io_levels: assert property (t1 && io |-> !normal_system && memory_request_n)
        else $error("io levels");
    a_io_strobe: assert property (t1 && io |=> !data_strobe_n [*2])
        else $error("io strobe");
    a_input_float: assert property (t1 && io && read_write |=> !muxed_addr_data_bus_oe)
        else $error("input bus driven");
    a_output_drive: assert property (t1 && io && !read_write |=> muxed_addr_data_bus_oe)
        else $error("output bus idle");
endmodule
bind bus_cycle_sequencer bus_cycle_sequencer_sva chk (.pclk(pclk), .presetn(presetn),
    .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
    .memory_request_n(memory_request_n), .read_write(read_write), .normal_system(normal_system),
    .cycle_status_code(cycle_status_code), .muxed_addr_data_bus_out(muxed_addr_data_bus_out),
    .muxed_addr_data_bus_oe(muxed_addr_data_bus_oe));

//--- test/bus_cycle_sequencer_tb_top.sv
// Self-checking bench: APB register traffic, events and bus cycles
`timescale 1ns/1ps
`include "bus_cycle_cfg.svh"
module bus_cycle_sequencer_tb_top;
    import bus_cycle_pkg::*;
    logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] bus_in, bus_out, rd_val = 16'h0, port, d, in16;
    logic bus_oe, as_n, ds_n, memory_request_n_n, rw, bw, ns, wait_n, nmi_n = 1, vi_n = 1, nvi_n = 1;
    logic brq_n = 1, back_n, coe;
    logic [3:0] code, wcnt = 4'h0;
    logic [37:0] e;
    logic [1:0] kind;
    logic byt, inp;
    logic [32:0] apb_q[$];
    logic [37:0] pin_q[$];
    logic [15:0] out_q[$];
    logic [15:0] fw[4] = '{16'h4000, 16'h5800, 16'h4800, 16'h4000};
    logic [15:0] ids[4] = '{`ID_PRIV, `ID_VECTORED, `ID_NONVECTORED, `ID_NMI};
    // Entry (pointer + slot) mod 4 with pointer 1: slots 0, 2, 3, 1
    logic [15:0] pcs[4] = '{16'h1001, 16'h1003, 16'h1000, 16'h1002};
    int errors = 0, checks_done = 0, i, w, dl, seed;
    bus_cycle_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .muxed_addr_data_bus_in(bus_in), .muxed_addr_data_bus_out(bus_out),
        .muxed_addr_data_bus_oe(bus_oe), .address_strobe_n(as_n), .data_strobe_n(ds_n),
        .memory_request_n(memory_request_n_n), .read_write(rw), .byte_word(bw), .normal_system(ns),
        .cycle_status_code(code), .control_oe(coe), .wait_n(wait_n), .bus_request_n(brq_n),
        .bus_acknowledge_n(back_n), .nmi_n(nmi_n), .vectored_irq_n(vi_n),
        .nonvectored_irq_n(nvi_n));
    io_peripheral_model peer (.pclk(pclk), .address_strobe_n(as_n), .data_strobe_n(ds_n),
        .read_write(rw), .bus_out(bus_out), .bus_oe(bus_oe), .read_value(rd_val),
        .wait_count(wcnt), .bus_in(bus_in), .wait_n(wait_n));
    initial begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One APB transfer; the monitor compares {pslverr, read data} with the note
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [32:0] x);
        int n;
        apb_q.push_back(x);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin errors++; test_done(); end
        {psel, penable} <= 2'b00;
    endtask
    // Waits for the next cycle start and counts data strobe clocks
    task automatic run_cycle(output int lo);
        int n;
        lo = 0;
        n = 0;
        while (as_n !== 1'b0 && n < 20) begin @(negedge pclk); n++; end
        if (n == 20) begin errors++; test_done(); end
        for (n = 0; n < 40; n++) begin
            @(negedge pclk);
            if (ds_n === 1'b0) lo++;
            else if (lo > 0 || n > 3) break;
        end
        repeat (3) @(negedge pclk);
    endtask
    // APB result monitor, sampled mid-cycle where values are settled
    always @(negedge pclk) begin
        if (psel && penable && pready)
            check({pslverr, pwrite ? 32'h0 : prdata}, apb_q.pop_front());
    end
    // Pin monitor: cycle start fields, then output data in T2
    always @(negedge pclk) begin
        if (presetn && !as_n) begin
            if (pin_q.size() == 0) check(40'h1, 40'h0);
            else begin
                e = pin_q.pop_front();
                check({code, bus_out & e[33:18], e[37:35] == 3'h1 ? {bw, rw} : 2'b00},
                    {e[37:34], e[17:0]});
                if (e[37:35] == 3'h1 && !e[0]) begin
                    @(negedge pclk);
                    check({bus_oe, bus_out}, {1'b1, out_q.pop_front()});
                end
            end
        end
    end
    initial begin
        seed = $urandom(53393);
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, `REG_FCW, 0, {17'h0, `FCW_RESET});
        apb(1, `REG_NSAP, 32'h1, 33'h0);
        for (i = 0; i < 4; i++)
            apb(1, `REG_AREA_BASE + 8'(4 * i), {16'h4000, 16'h1000 + 16'(i)}, 0);
        apb(1, `REG_PC, 32'h0abc, 33'h0);
        apb(1, `REG_CYCLE_CMD, 32'h0002_0040, 33'h0); // I/O in normal mode is refused
        repeat (8) @(posedge pclk);
        apb(0, `REG_SAVED_PC, 0, 33'h0abc);
        apb(0, `REG_SAVED_FCW, 0, 33'h0);
        apb(0, `REG_FCW, 0, 33'h4000);
        // Interrupt table: disabled, vectored over non-vectored, non-vectored, edge request
        for (i = 0; i < 4; i++) begin
            apb(1, `REG_FCW, {16'h0, fw[i]}, 33'h0);
            @(posedge pclk);
            {vi_n, nvi_n, nmi_n} <= {i > 1, i > 2, i != 3};
            repeat (8) @(posedge pclk);
            {vi_n, nvi_n, nmi_n} <= 3'b111;
            apb(0, `REG_SAVED_ID, 0, {17'h0, ids[i]});
            apb(0, `REG_PC, 0, {17'h0, pcs[i]});
        end
        // I/O cycles: every kind, direction and width, random data, random wait on special I/O only
        for (i = 0; i < 8; i++) begin
            {port, d} = $urandom;
            rd_val <= 16'($urandom);
            w = i[0] ? $urandom_range(6, 4) : 0;
            wcnt <= 4'(w);
            {byt, inp, kind} = {i[2], i[1], 1'b1, i[0]};
            apb(1, `REG_CYCLE_DATA, {16'h0, d}, 33'h0);
            pin_q.push_back({2'b00, kind, 16'hffff, port, byt, inp});
            if (!inp) out_q.push_back(byt ? {2{d[7:0]}} : d);
            apb(1, `REG_CYCLE_CMD, {12'h0, byt, inp, kind, port}, 33'h0);
            run_cycle(dl);
            check(40'(w == 0 ? dl == 2 : dl > 2 && dl <= w + 4), 40'h1);
            in16 = !byt ? rd_val : {8'h0, port[0] ? rd_val[7:0] : rd_val[15:8]};
            if (inp) apb(0, `REG_CYCLE_DATA, 0, {1'b0, in16, d});
        end
        // Internal then refresh cycle: no strobe, no wait
        for (i = 0; i < 2; i++) begin
            pin_q.push_back({3'h0, i[0], 15'h0, i[0], 18'h0});
            apb(1, `REG_CYCLE_CMD, {14'h0, 2'(i), 16'h0}, 33'h0);
            run_cycle(dl);
            check(40'(dl), 40'h0);
        end
        // Bus grant: a refresh command waits until the other master lets go
        @(posedge pclk);
        brq_n <= 0;
        repeat (4) @(negedge pclk);
        check({back_n, coe}, 40'h0);
        apb(1, `REG_CYCLE_CMD, 32'h0001_0000, 33'h0);
        repeat (6) @(posedge pclk);
        pin_q.push_back({3'h0, 1'b1, 15'h0, 1'b1, 18'h0});
        brq_n <= 1;
        run_cycle(dl);
        check({back_n, coe, 8'(dl)}, 40'h300);
        apb(0, 8'h3c, 0, {1'b1, 32'h0});
        apb(1, 8'h02, 32'hffff, {1'b1, 32'h0});
        test_done();
    end
endmodule

//--- test/io_peripheral_model.sv
// I/O peripheral stand-in: answers input cycles and stretches them with wait
`timescale 1ns/1ps
module io_peripheral_model (
    input wire logic pclk,
    input wire logic address_strobe_n,
    input wire logic data_strobe_n,
    input wire logic read_write,
    input wire logic [15:0] bus_out,
    input wire logic bus_oe,
    input wire logic [15:0] read_value,
    input wire logic [3:0] wait_count,
    output logic [15:0] bus_in,
    output logic wait_n
);
    logic [15:0] last_bus = 16'h0;
    logic [3:0] wait_left = 4'h0;
    // Released bus shows the inverse of its last level, so stale data never passes
    assign bus_in = bus_oe ? bus_out :
        (!data_strobe_n && read_write) ? read_value : ~last_bus;
    // Wait drops already in T1: the device sees the pin two clocks late
    assign wait_n = !((!address_strobe_n && wait_count != 4'h0) ||
        wait_left != 4'h0);
    // Counter keeps wait low for wait_count clocks after the address strobe
    always_ff @(posedge pclk) begin
        last_bus <= bus_in;
        if (!address_strobe_n) begin
            wait_left <= wait_count;
        end else if (wait_left != 4'h0) begin
            wait_left <= wait_left - 4'h1;
        end
    end
endmodule
